// ---- srtg_top.sv ----
`timescale 1ns/1ps
module srtg_top #(
    parameter int NUM_OUT = 6,
    parameter logic [7:0] DIV_HALF = srtg_pkg::RST_DIV_HALF
) (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic srst,
    // Register port.
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    // Trigger pin.
    input wire logic multipurpose_pin_13,
    // Outputs.
    output logic dev_clk_en,
    output logic [NUM_OUT-1:0] clock_output
);

    ////////////////////////////////////////////////////////////////////////
    // Register state; the active trigger copy changes only on an update pulse.
    logic [7:0] page_reg;
    logic [7:0] page_next;
    logic [7:0] trig_en_reg;
    logic [7:0] trig_en_next;
    logic [7:0] trig_act_reg;
    logic [7:0] trig_act_next;
    logic [7:0] upd_reg;
    logic [7:0] upd_next;
    logic [7:0] onehot_reg;
    logic [7:0] onehot_next;
    logic [7:0] sw_gate_reg;
    logic [7:0] sw_gate_next;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic on_loop_b;
    logic on_generic;
    logic hit_page;
    logic hit_trig_en;
    logic hit_update;
    logic hit_onehot;
    logic hit_sw_gate;
    logic update_rise;

    assign on_loop_b = page_reg == srtg_pkg::PAGE_LOOP_B;
    assign on_generic = page_reg == srtg_pkg::PAGE_GENERIC;

    // The page register answers on every page; the others only on their own page.
    always_comb
    begin
        hit_page = reg_addr == srtg_pkg::OFS_PAGE;
        hit_trig_en = on_generic && reg_addr == srtg_pkg::OFS_TRIG_EN;
        hit_update = on_generic && reg_addr == srtg_pkg::OFS_UPDATE;
        hit_onehot = on_loop_b && reg_addr == srtg_pkg::OFS_ONEHOT_SEL;
        hit_sw_gate = on_loop_b && reg_addr == srtg_pkg::OFS_SW_GATE;
        update_rise = reg_wdata[srtg_pkg::UPDATE_BIT] && !upd_reg[srtg_pkg::UPDATE_BIT];
    end

    always_comb
    begin
        page_next = page_reg;
        trig_en_next = trig_en_reg;
        trig_act_next = trig_act_reg;
        upd_next = upd_reg;
        onehot_next = onehot_reg;
        sw_gate_next = sw_gate_reg;
        rdata_next = rdata_reg;
        if (reg_wr)
        begin
            if (hit_page)
            begin
                page_next = reg_wdata;
            end
            else if (hit_trig_en)
            begin
                trig_en_next = reg_wdata;
            end
            else if (hit_update)
            begin
                upd_next = reg_wdata;
                // Only a low-to-high step of the update bit copies the settings, so a
                // repeated write with the bit still set leaves the active copy alone.
                if (update_rise)
                begin
                    trig_act_next = trig_en_reg;
                end
            end
            else if (hit_onehot)
            begin
                onehot_next = {2'b00, reg_wdata[5:0]};
            end
            else if (hit_sw_gate)
            begin
                sw_gate_next = reg_wdata;
            end
        end
        if (reg_rd)
        begin
            // Unmapped offsets and registers of the other page read as zero.
            rdata_next = 8'h00;
            if (hit_page)
            begin
                rdata_next = page_reg;
            end
            else if (hit_trig_en)
            begin
                rdata_next = trig_en_reg;
            end
            else if (hit_update)
            begin
                rdata_next = upd_reg;
            end
            else if (hit_onehot)
            begin
                rdata_next = onehot_reg;
            end
            else if (hit_sw_gate)
            begin
                rdata_next = sw_gate_reg;
            end
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            page_reg <= srtg_pkg::RST_PAGE;
            trig_en_reg <= srtg_pkg::RST_TRIG_EN;
            trig_act_reg <= srtg_pkg::RST_TRIG_EN;
            upd_reg <= srtg_pkg::RST_UPDATE;
            onehot_reg <= srtg_pkg::RST_ONEHOT;
            sw_gate_reg <= srtg_pkg::RST_SW_GATE;
            rdata_reg <= 8'h00;
        end
        else
        begin
            page_reg <= page_next;
            trig_en_reg <= trig_en_next;
            trig_act_reg <= trig_act_next;
            upd_reg <= upd_next;
            onehot_reg <= onehot_next;
            sw_gate_reg <= sw_gate_next;
            rdata_reg <= rdata_next;
        end
    end

    assign reg_rdata = rdata_reg;

    ////////////////////////////////////////////////////////////////////////
    // Internal SYSREF is a divide of ref_clk, which stands in for the device clock.
    // Rises of the divided copy are marked by a one-cycle enable; nothing is clocked by it.
    logic [7:0] div_cnt_reg;
    logic [7:0] div_cnt_next;
    logic sysref_reg;
    logic sysref_next;
    logic sysref_rise;

    always_comb
    begin
        div_cnt_next = div_cnt_reg + 8'h01;
        sysref_next = sysref_reg;
        if (div_cnt_reg >= DIV_HALF - 8'h01)
        begin
            div_cnt_next = 8'h00;
            sysref_next = !sysref_reg;
        end
    end

    assign sysref_rise = (div_cnt_reg >= DIV_HALF - 8'h01) && !sysref_reg;

    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            div_cnt_reg <= 8'h00;
            sysref_reg <= 1'b0;
        end
        else
        begin
            div_cnt_reg <= div_cnt_next;
            sysref_reg <= sysref_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Two stages synchronise the trigger pin to ref_clk before the gate logic reads it.
    logic req_s1_reg;
    logic req_s1_next;
    logic req_s2_reg;
    logic req_s2_next;
    logic gate_reg;
    logic gate_next;
    logic gate_src;

    // Only the second stage is read; the first may still be settling.
    always_comb
    begin
        req_s1_next = multipurpose_pin_13;
        req_s2_next = req_s1_reg;
    end

    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            req_s1_reg <= 1'b0;
            req_s2_reg <= 1'b0;
        end
        else
        begin
            req_s1_reg <= req_s1_next;
            req_s2_reg <= req_s2_next;
        end
    end

    // The pin drives the gate only for loop_b with its trigger enabled; software gate otherwise.
    // The two sources are ORed, so either one alone keeps the output running.
    always_comb
    begin
        gate_src = sw_gate_reg[srtg_pkg::SW_GATE_BIT];
        if (trig_act_reg[srtg_pkg::LOOP_B_BIT])
        begin
            gate_src = req_s2_reg || sw_gate_reg[srtg_pkg::SW_GATE_BIT];
        end
        gate_next = gate_reg;
        // The gate is resampled only at a SYSREF rise, so a high or low phase is never cut.
        if (sysref_rise)
        begin
            gate_next = gate_src;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            gate_reg <= 1'b0;
        end
        else
        begin
            gate_reg <= gate_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Output drivers follow the internal SYSREF while gated and rest high while blocked.
    // Unselected outputs are held low so that a stray select bit shows up at once.
    logic [NUM_OUT-1:0] out_reg;
    logic [NUM_OUT-1:0] out_next;
    logic dev_en_reg;
    logic dev_en_next;

    genvar gi;
    generate
        for (gi = 0; gi < NUM_OUT; gi++)
        begin : g_out
            always_comb
            begin
                out_next[gi] = 1'b0;
                if (onehot_reg[gi])
                    out_next[gi] = gate_next ? sysref_next : 1'b1;
            end
        end
    endgenerate

    // A marker in the same cycle as each SYSREF rise, for whoever aligns to the divided copy.
    always_comb
    begin
        dev_en_next = sysref_rise;
    end

    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            out_reg <= '0;
            dev_en_reg <= 1'b0;
        end
        else
        begin
            out_reg <= out_next;
            dev_en_reg <= dev_en_next;
        end
    end

    assign clock_output = out_reg;
    assign dev_clk_en = dev_en_reg;

endmodule // srtg_top

// ---- srtg_pkg.sv ----
package srtg_pkg;
    // Register offsets.
    localparam logic [7:0] OFS_ONEHOT_SEL = 8'h09;
    localparam logic [7:0] OFS_SW_GATE = 8'h05;
    localparam logic [7:0] OFS_UPDATE = 8'h0F;
    localparam logic [7:0] OFS_TRIG_EN = 8'h19;
    localparam logic [7:0] OFS_PAGE = 8'hFF;
    // Page codes.
    localparam logic [7:0] PAGE_GENERIC = 8'h00;
    localparam logic [7:0] PAGE_LOOP_B = 8'h0B;
    // Field positions.
    localparam int UPDATE_BIT = 2;
    localparam int SW_GATE_BIT = 1;
    localparam int LOOP_B_BIT = 1;
    // Reset values.
    localparam logic [7:0] RST_PAGE = 8'h00;
    localparam logic [7:0] RST_TRIG_EN = 8'h20;
    localparam logic [7:0] RST_UPDATE = 8'h00;
    localparam logic [7:0] RST_ONEHOT = 8'h00;
    localparam logic [7:0] RST_SW_GATE = 8'h00;
    localparam logic [7:0] RST_DIV_HALF = 8'h04;
endpackage

// ---- srtg_assertions.sv ----
`timescale 1ns/1ps
module srtg_checker #(parameter int NUM_OUT = 6) (
    // Watched ports.
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic dev_clk_en,
    input wire logic [NUM_OUT-1:0] clock_output
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (srst);
    // Bit 3 is the output the bench selects; full half periods rule out runt pulses.
    property p_period; dev_clk_en |-> ##8 dev_clk_en; endproperty
    a_period: assert property (p_period) else $error("bad period");
    property p_gap; dev_clk_en |=> !dev_clk_en [*7]; endproperty
    a_gap: assert property (p_gap) else $error("early marker");
    property p_fall; $fell(clock_output[3]) |-> $past(clock_output[3], 4); endproperty
    a_fall: assert property (p_fall) else $error("short high");
    property p_rise; $rose(clock_output[3]) |-> !$past(clock_output[3], 4); endproperty
    a_rise: assert property (p_rise) else $error("short low");
    property p_page;
        reg_wr && reg_addr == 8'hFF ##2 reg_rd && reg_addr == 8'hFF
            |=> reg_rdata == $past(reg_wdata, 3);
    endproperty
    a_page: assert property (p_page) else $error("page lost");
    property p_hold; !reg_rd |=> $stable(reg_rdata); endproperty
    a_hold: assert property (p_hold) else $error("rdata moved");
endmodule // srtg_checker
////////////////////////////////////////
bind srtg_top srtg_checker #(.NUM_OUT(NUM_OUT)) srtg_checker_i (.ref_clk(ref_clk), .srst(srst),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .dev_clk_en(dev_clk_en), .clock_output(clock_output));

// ---- srtg_fpga_model.sv ----
`timescale 1ns/1ps
// Pin moves off the rising edge, so the design's synchroniser sees an unrelated change.
module srtg_fpga_model (
    // Clock and command.
    input wire logic ref_clk,
    input wire logic want_ref,
    // Trigger pin.
    output logic multipurpose_pin_13
);
    initial
    begin
        multipurpose_pin_13 = 1'b0;
        forever @(negedge ref_clk) multipurpose_pin_13 <= want_ref;
    end
endmodule // srtg_fpga_model

// ---- srtg_tb.sv ----
`timescale 1ns/1ps
module tb;
    logic ref_clk = 1'b0, srst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, want_ref = 1'b0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
    logic pin, dev_clk_en;
    logic [5:0] clock_output;
    int num_errors = 0, comparisons = 0;
    always #5 ref_clk = ~ref_clk;
    srtg_top srtg_top_i (.ref_clk(ref_clk), .srst(srst), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .multipurpose_pin_13(pin), .dev_clk_en(dev_clk_en), .clock_output(clock_output));
    srtg_fpga_model srtg_fpga_model_i (.ref_clk(ref_clk), .want_ref(want_ref),
        .multipurpose_pin_13(pin));
    ////////////////////////////////////////
    task automatic chk(logic [7:0] got, logic [7:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(negedge ref_clk);
        {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
        @(negedge ref_clk);
        reg_wr = 1'b0;
    endtask
    task automatic rd(logic [7:0] a, logic [7:0] e);
        @(negedge ref_clk);
        {reg_rd, reg_addr} = {1'b1, a};
        @(negedge ref_clk);
        reg_rd = 1'b0;
        chk(reg_rdata, e);
    endtask
    // Settle covers two sync flops plus a whole period; 32 cycles are four periods.
    task automatic obs(logic [7:0] lows);
        int n;
        int bad;
        int en;
        n = 0;
        bad = 0;
        en = 0;
        repeat (16) @(negedge ref_clk);
        repeat (32)
        begin
            @(negedge ref_clk);
            n += int'(clock_output[3] !== 1'b1);
            bad += int'(clock_output[5:4] !== 2'h0 || clock_output[2:0] !== 3'h0);
            en += int'(dev_clk_en === 1'b1);
        end
        chk(8'(n), lows);
        chk(8'(bad), 8'h00);
        chk(8'(en), 8'h04);
    endtask
    ////////////////////////////////////////
    task automatic t_rst;
        rd(8'hFF, 8'h00);
        rd(8'h19, 8'h20);
        rd(8'h0F, 8'h00);
        wr(8'hFF, 8'h0B);
        rd(8'hFF, 8'h0B);
        rd(8'h19, 8'h00);
        rd(8'h09, 8'h00);
        rd(8'h05, 8'h00);
    endtask
    task automatic t_pin;
        wr(8'h09, 8'hC8);
        rd(8'h09, 8'h08);
        want_ref = 1'b1;
        obs(8'h00);
        wr(8'hFF, 8'h00);
        wr(8'h19, 8'h22);
        rd(8'h19, 8'h22);
        wr(8'h0F, 8'h00);
        wr(8'h0F, 8'h04);
        wr(8'h0F, 8'h00);
        obs(8'h10);
        want_ref = 1'b0;
        obs(8'h00);
    endtask
    task automatic t_sw;
        wr(8'hFF, 8'h0B);
        wr(8'h05, 8'h02);
        rd(8'h05, 8'h02);
        obs(8'h10);
        wr(8'h05, 8'h00);
        obs(8'h00);
    endtask
    // A reset in mid-run must drop the select and the page picked up so far.
    task automatic t_rerun;
        @(negedge ref_clk);
        srst = 1'b1;
        repeat (3) @(negedge ref_clk);
        srst = 1'b0;
        rd(8'hFF, 8'h00);
        rd(8'h19, 8'h20);
        obs(8'h20);
    endtask
    task automatic stop_test;
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial
    begin
        repeat (3) @(negedge ref_clk);
        srst = 1'b0;
        t_rst;
        t_pin;
        t_sw;
        t_rerun;
        stop_test;
    end
    initial
    begin
        #20000;
        num_errors++;
        stop_test;
    end
endmodule // tb
